// ---- inc/mif_pkg.sv ----
// types shared by the interrupt flag block
package mif_pkg;
  typedef struct packed {
    logic cycle_start;
    logic cycle_done;
    logic current_sum_excess;
    logic accum_overflow;
  } mif_dsp_evt_s;
  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } mif_reg_req_s;
endpackage

// ---- inc/mif_regs.svh ----
// register offsets, flag bit positions and reset values of the interrupt flag block
`ifndef MIF_REGS_SVH
`define MIF_REGS_SVH
`define MIF_FLAG_OFS      12'h004
`define MIF_MASK_OFS      12'h006
`define MIF_FLAG_RST      16'h0000
`define MIF_MASK_RST      16'h0000
`define MIF_FLAG_IMPL     16'hFF0F
`define MIF_BIT_OVERRUN   15
`define MIF_BIT_DONE      14
`define MIF_BIT_REACT_DIR 13
`define MIF_BIT_REAL_DIR  12
`define MIF_BIT_ZERO_CROSS_MISSING_FLAG      11
`define MIF_BIT_VLOW      10
`define MIF_BIT_VHIGH     9
`define MIF_BIT_IHIGH     8
`define MIF_BIT_ISUM      3
`define MIF_BIT_ENERGY_ACCUM_OVERFLOW_FLAG      2
`define MIF_BIT_CONFIG_CHECKSUM    1
`define MIF_BIT_PFAIL     0
`endif

// ---- verification/mif_flags_bench.sv ----
// self-checking bench for the interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module mif_flags_bench;
  logic                  clock, rst, ir, p, reactive_dir, real_dir, pf, irq_n;
  logic [15:0]           ck, s, reg_rdata, uvt, ovt, oct;
  logic [2:0]            zx;
  logic [47:0]           v;
  logic [63:0]           c;
  mif_pkg::mif_dsp_evt_s e;
  mif_pkg::mif_reg_req_s req;
  logic [15:0]           q[$];
  int                    failures, compares;
  mif_host host_u (.clock(clock), .req(req));
  // crossings high and thresholds at extremes keep bits 11..8 quiet outside the level test
  mif_flags dut_u (.clock(clock), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata), .dsp_evt(e),
    .reactive_dir(reactive_dir), .real_dir(real_dir), .zero_cross(zx), .voltage_abs(v), .current_abs(c),
    .undervoltage_threshold(uvt), .overvoltage_threshold(ovt), .overcurrent_threshold(oct),
    .config_checksum(ck), .power_fail_pin(pf), .irq_n(irq_n));
  initial
  begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    repeat (3000) @(posedge clock);
    failures++;
    wrap_up;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // never zero, so every sample sits strictly above a zero threshold
  always @(posedge clock)
  begin
    if (rst) s <= 16'h0018;
    else s <= lfsr(s);
    v <= {3{s}};
    c <= {4{s}};
  end
  task cmp_rd(input logic [15:0] g);
    logic [15:0] x;
    x = q.pop_front();
    compares++;
    if (g !== x)
    begin
      failures++;
      $display("unexpected read at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task cmp_irq(input logic g);
    logic [15:0] x;
    x = q.pop_front();
    compares++;
    if ({15'h0000, g} !== x)
    begin
      failures++;
      $display("unexpected irq_n at %0t got %h exp %h", $time, g, x[0]);
    end
  endtask
  always @(posedge clock)
  begin
    if (p) cmp_rd(reg_rdata);
    if (ir) cmp_irq(irq_n);
    p <= req.rd;
  end
  task rd(input logic [11:0] a, input logic [15:0] x);
    q.push_back(x);
    host_u.acc(a, 1'b0, 16'h0000);
  endtask
  task look(input logic x);
    q.push_back({15'h0000, x});
    @(posedge clock) ir <= 1;
    @(posedge clock) ir <= 0;
  endtask
  task ev(input mif_pkg::mif_dsp_evt_s x);
    @(posedge clock) e <= x;
    @(posedge clock) e <= '0;
  endtask
  task wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    {rst, ir, reactive_dir, real_dir, pf} = 5'h10;
    e = '0;
    ck = 16'h1234;
    zx = 3'h7;
    uvt = 16'h0000;
    ovt = 16'hFFFF;
    oct = 16'hFFFF;
    repeat (3) @(posedge clock);
    rst <= 0;
    rd(12'h004, 16'h0000);
    rd(12'h006, 16'h0000);
    rd(12'h00A, 16'h0000);
    $display("reset test done");
    @(posedge clock) pf <= 1;
    @(posedge clock) pf <= 0;
    @(posedge clock);
    rd(12'h004, 16'h0001);
    {reactive_dir, real_dir} <= 2'h3;
    ck <= ~ck;
    ev(4'h8);
    ev(4'h8);
    ev(4'h7);
    rd(12'h004, 16'hF00F);
    host_u.acc(12'h004, 1'b1, 16'hFFFF);
    rd(12'h004, 16'h0000);
    $display("event test done");
    // channel 2 silent and every threshold tripped across one whole dsp cycle
    zx <= 3'h3;
    uvt <= 16'hFFFF;
    ovt <= 16'h0000;
    oct <= 16'h0000;
    ev(4'h4);
    ev(4'h4);
    zx <= 3'h7;
    uvt <= 16'h0000;
    ovt <= 16'hFFFF;
    oct <= 16'hFFFF;
    rd(12'h004, 16'h4F00);
    host_u.acc(12'h004, 1'b1, 16'hFFFF);
    rd(12'h004, 16'h0000);
    $display("level test done");
    ev(4'h4);
    host_u.acc(12'h006, 1'b1, 16'hFFFF);
    look(1'b0);
    rd(12'h006, 16'hFF0F);
    host_u.acc(12'h006, 1'b1, 16'hBFFF);
    look(1'b1);
    fork
      host_u.acc(12'h004, 1'b1, 16'h4000);
      ev(4'h4);
    join
    rd(12'h004, 16'h4000);
    host_u.acc(12'h004, 1'b1, 16'h4000);
    host_u.acc(12'h006, 1'b1, 16'h0000);
    rd(12'h004, 16'h0000);
    $display("mask test done");
    repeat (3) @(posedge clock);
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- verification/mif_flags_properties.sv ----
// concurrent checks on the interrupt flag block ports
`timescale 1ns/10ps
`default_nettype none
module mif_flags_properties
(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire mif_pkg::mif_reg_req_s reg_req,
  input wire logic [15:0]           reg_rdata,
  input wire mif_pkg::mif_dsp_evt_s dsp_evt,
  input wire logic                  power_fail_pin,
  input wire logic                  irq_n
);
  wire r4 = reg_req.rd && !reg_req.wr && reg_req.addr == 12'h004;
  wire w4 = reg_req.wr && reg_req.addr == 12'h004;
  wire w6 = reg_req.wr && reg_req.addr == 12'h006;
  wire un = reg_req.rd && reg_req.addr != 12'h004 && reg_req.addr != 12'h006;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($fell(rst) |-> irq_n && reg_rdata == 16'h0000)
    else $error("not idle after reset");
  a_mask_reset: assert property ($fell(rst) ##0 (!w6) [*4] |=> irq_n)
    else $error("irq with mask at reset value");
  a_mask_zero: assert property (w6 && reg_req.wdata == 16'h0000 |=> irq_n)
    else $error("irq with mask cleared");
  a_done_flag: assert property (dsp_evt.cycle_done ##1 !w4 ##1 r4 |=> reg_rdata[14])
    else $error("done flag lost");
  a_pfail_flag: assert property (power_fail_pin ##3 r4 |=> reg_rdata[0])
    else $error("power fail flag missing");
  a_unmapped_zero: assert property (un |=> reg_rdata == 16'h0000)
    else $error("unmapped read nonzero");
  a_read_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_reserved_zero: assert property (reg_rdata[7:4] == 4'h0)
    else $error("reserved bits read nonzero");
endmodule
bind mif_flags mif_flags_properties chk_u (.clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .dsp_evt(dsp_evt), .power_fail_pin(power_fail_pin), .irq_n(irq_n));
`default_nettype wire

// ---- verification/mif_host.sv ----
// host model issuing register reads and writes
`timescale 1ns/10ps
`default_nettype none
module mif_host
(
  input  wire logic                 clock,
  output var mif_pkg::mif_reg_req_s req
);
  initial req = '0;
  task acc(input logic [11:0] a, input logic w, input logic [15:0] d);
    @(posedge clock);
    req <= '{a, w, !w, d};
    @(posedge clock);
    // released bus shows inverted values, not stale ones
    req <= '{~a, 1'b0, 1'b0, ~d};
  endtask
endmodule
`default_nettype wire

// ---- verilog/mif_flags.sv ----
// interrupt cause flags, enable register and active-low interrupt request pin
//
// Overview of operation
// [RULE1] set bit 15 when a new dsp cycle starts before the previous one finished
// [RULE2] set bit 14 whenever a dsp cycle completes
// [RULE3] set bit 13 when reactive energy direction reverses either way
// [RULE4] set bit 12 when real energy direction reverses either way
// [RULE5] set bit 11 when any voltage channel saw no zero crossing in a cycle
// [RULE6] set bit 10 when any voltage stays at or below undervoltage threshold all cycle
// [RULE7] set bit 9 when any absolute voltage rises above the overvoltage threshold
// [RULE8] set bit 8 when any absolute current rises above the overcurrent threshold
// [RULE9] set bit 3 when current vector sum exceeds its threshold
// [RULE10] set bit 2 when any energy accumulator msb overflows
// [RULE11] set bit 1 whenever the configuration checksum changes value
// [RULE12] set bit 0 while a supply failure is imminent
// [RULE13] host reads the flags to find the interrupt cause
// [RULE14] host clears each serviced flag, else the request stays asserted
// [RULE15] host should review every configuration checksum change
// [RULE16] request pin active only for flags whose enable bit is set
// [RULE17] enable register resets to zero
// [RULE18] flags stay set until cleared; a same-cycle event beats the clear
// [RULE19] reserved flag bits 7 to 4 read zero and ignore writes
`timescale 1ns/10ps
`default_nettype none
`include "mif_regs.svh"

module mif_flags
#(
  parameter int NV = 3,
  parameter int NI = 4,
  parameter int DW = 16
)
(
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire mif_pkg::mif_reg_req_s  reg_req,
  output logic [15:0]                 reg_rdata,
  input  wire mif_pkg::mif_dsp_evt_s  dsp_evt,
  input  wire logic                   reactive_dir,
  input  wire logic                   real_dir,
  input  wire logic [NV-1:0]          zero_cross,
  input  wire logic [NV*DW-1:0]       voltage_abs,
  input  wire logic [NI*DW-1:0]       current_abs,
  input  wire logic [DW-1:0]          undervoltage_threshold,
  input  wire logic [DW-1:0]          overvoltage_threshold,
  input  wire logic [DW-1:0]          overcurrent_threshold,
  input  wire logic [15:0]            config_checksum,
  input  wire logic                   power_fail_pin,
  output logic                        irq_n
);

  generate
    if (NV < 1 || NI < 1 || DW < 1 || DW > 32)
    begin : g_bad_param
      $error("mif_flags: unsupported channel count or sample width");
    end
  endgenerate

  logic [15:0]   flags;
  logic [15:0]   mask;
  logic [15:0]   next_flags;
  logic [NV-1:0] zx_seen;
  logic [NV-1:0] above_uv;
  logic          busy;
  logic          react_q;
  logic          real_q;
  logic [15:0]   chk_q;
  logic          chk_valid;
  logic          pf_meta;
  logic          pf_sync;

  // register decode
  wire flag_sel = reg_req.addr == `MIF_FLAG_OFS;
  wire mask_sel = reg_req.addr == `MIF_MASK_OFS;
  wire flag_wr  = reg_req.wr && flag_sel;
  wire mask_wr  = reg_req.wr && mask_sel;

  // per-channel comparisons
  logic [NV-1:0] v_high;
  logic [NV-1:0] v_above_uv;
  logic [NI-1:0] i_high;
  genvar g;
  generate
    for (g = 0; g < NV; g++)
    begin : g_v
      assign v_high[g]     = voltage_abs[g*DW +: DW] > overvoltage_threshold;
      assign v_above_uv[g] = voltage_abs[g*DW +: DW] > undervoltage_threshold;
    end
    for (g = 0; g < NI; g++)
    begin : g_i
      assign i_high[g] = current_abs[g*DW +: DW] > overcurrent_threshold;
    end
  endgenerate

  // events of this cycle, one bit per flag
  wire cyc_end      = dsp_evt.cycle_done;
  wire ev_overrun   = dsp_evt.cycle_start && busy && !cyc_end; // [RULE1]
  wire ev_done      = cyc_end; // [RULE2]
  wire ev_react     = reactive_dir != react_q; // [RULE3]
  wire ev_real      = real_dir != real_q; // [RULE4]
  // this cycle's crossings and levels count toward the closing cycle
  wire ev_zero_cross_missing_flag      = cyc_end && !(&(zx_seen | zero_cross)); // [RULE5]
  wire ev_vlow      = cyc_end && !(&(above_uv | v_above_uv)); // [RULE6]
  wire ev_vhigh     = |v_high; // [RULE7]
  wire ev_ihigh     = |i_high; // [RULE8]
  wire ev_isum      = dsp_evt.current_sum_excess; // [RULE9]
  wire ev_energy_accum_overflow_flag      = dsp_evt.accum_overflow; // [RULE10]
  wire ev_chk       = chk_valid && (config_checksum != chk_q); // [RULE11]
  wire ev_pfail     = pf_sync; // [RULE12]

  wire [15:0] events = {ev_overrun, ev_done, ev_react, ev_real, ev_zero_cross_missing_flag, ev_vlow, ev_vhigh, ev_ihigh,
                        4'h0, ev_isum, ev_energy_accum_overflow_flag, ev_chk, ev_pfail};

  // write one to clear; set beats clear in the same cycle
  wire [15:0] clr_bits = flag_wr ? reg_req.wdata : 16'h0000;
  assign next_flags = ((flags & ~clr_bits) | events) & `MIF_FLAG_IMPL; // [RULE18] [RULE19]

  wire [15:0] rd_mux = flag_sel ? flags :
                       mask_sel ? mask  : 16'h0000;

  // irq follows an enable write at once, so a disabled flag never pulls it one cycle late
  wire [15:0] next_mask = mask_wr ? (reg_req.wdata & `MIF_FLAG_IMPL) : mask;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      flags <= `MIF_FLAG_RST;
      mask  <= `MIF_MASK_RST; // [RULE17]
    end
    else
    begin
      flags <= next_flags;
      if (mask_wr)
      begin
        mask <= reg_req.wdata & `MIF_FLAG_IMPL;
      end
    end
  end

  // read data sampled on the read strobe, holds until the next read
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_req.rd)
    begin
      reg_rdata <= rd_mux; // [RULE13]
    end
  end

  // request stays low while any enabled flag is left uncleared
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      irq_n <= 1'b1;
    end
    else
    begin
      irq_n <= ~|(next_flags & next_mask); // [RULE16] [RULE14]
    end
  end

  // dsp cycle tracking: busy between start and done
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      busy     <= 1'b0;
      zx_seen  <= '0;
      above_uv <= '0;
    end
    else
    begin
      if (dsp_evt.cycle_start)
      begin
        busy <= 1'b1;
      end
      else if (cyc_end)
      begin
        busy <= 1'b0;
      end
      zx_seen  <= cyc_end ? '0 : (zx_seen | zero_cross);
      above_uv <= cyc_end ? '0 : (above_uv | v_above_uv);
    end
  end

  // direction and checksum history; first checksum after reset is a baseline, not a change
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      react_q   <= 1'b0;
      real_q    <= 1'b0;
      chk_q     <= 16'h0000;
      chk_valid <= 1'b0;
    end
    else
    begin
      react_q   <= reactive_dir;
      real_q    <= real_dir;
      chk_q     <= config_checksum;
      chk_valid <= 1'b1;
    end
  end

  // power fail comparator arrives asynchronously
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pf_meta <= 1'b0;
      pf_sync <= 1'b0;
    end
    else
    begin
      pf_meta <= power_fail_pin;
      pf_sync <= pf_meta;
    end
  end

endmodule

`default_nettype wire
